// [spi_port_status_register_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"
module spi_port_status_register_tb;
    logic        mclk, rst, wr, rd, irq, sck_o, sdo, sdi, busy, p_cke;
    logic        sck_oe;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata;
    logic [7:0]  p_tx, p_rx;
    int          num_errors = 0;
    int          comparisons = 0;
    sps_port dut_u (.mclk(mclk), .rst(rst), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .sck_o(sck_o), .sck_oe(sck_oe), .sck_i(1'b0), .sdo(sdo), .sdi(sdi),
        .busy(busy));
    sps_peer peer_u (.mclk(mclk), .rst(rst), .sck(sck_o), .sel(busy),
        .sdo(sdo), .cke(p_cke), .tx(p_tx), .sdi(sdi), .rx(p_rx));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        d = rdata;
    endtask : bus_rd
    task automatic wait_busy(input logic lvl);
        for (int n = 0; busy !== lvl; n++) begin
            if (n == 300) num_errors++;
            if (n == 300) tally_and_finish();
            @(posedge mclk);
        end
    endtask : wait_busy
    task automatic t_regs;
        logic [15:0] d;
        bus_rd(`SPS_ADDR_STAT, d);
        chk(d, 16'h0000);
        bus_rd(4'hf, d);
        chk(d, 16'h0000);
        bus_wr(`SPS_ADDR_STAT, 16'hffff);
        bus_rd(`SPS_ADDR_STAT, d);
        chk(d, 16'h00c0);
        $display("register test done");
    endtask : t_regs
    task automatic t_frame(input logic s, input logic c, input logic [7:0] b);
        logic [15:0] d;
        bus_wr(`SPS_ADDR_CTRL, 16'h0005);
        bus_wr(`SPS_ADDR_STAT, {8'h00, s, c, 6'h00});
        bus_wr(`SPS_ADDR_IRQ_EN, {15'h0000, s});
        p_tx  <= ~b;
        p_cke <= c;
        bus_wr(`SPS_ADDR_BUF, {8'h00, b});
        wait_busy(1'b1);
        chk({15'h0000, sck_oe}, 16'h0001);
        wait_busy(1'b0);
        repeat (3) @(posedge mclk);
        chk({15'h0000, irq}, {15'h0000, s});
        bus_rd(`SPS_ADDR_STAT, d);
        chk(d, {8'h00, s, c, 6'h01});
        chk({8'h00, p_rx}, {8'h00, b});
        bus_rd(`SPS_ADDR_BUF, d);
        chk(d, {8'h00, ~b});
        bus_rd(`SPS_ADDR_STAT, d);
        chk(d, {8'h00, s, c, 6'h00});
        bus_wr(`SPS_ADDR_IRQ_CLR, 16'h0001);
        repeat (2) @(posedge mclk);
        chk({15'h0000, irq}, 16'h0000);
        $display("frame smp %0d cke %0d done", s, c);
    endtask : t_frame
    // free-running system clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // resets, then runs the register test and every smp/cke pairing
    initial begin
        {rst, wr, rd, p_cke} = 4'b1000;
        addr  = 4'h0;
        wdata = 16'h0000;
        p_tx  = 8'h00;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        for (int i = 0; i < 4; i++) t_frame(i[1], i[0], 8'h96 ^ 8'(i));
        tally_and_finish();
    end
endmodule : spi_port_status_register_tb
`default_nettype wire

// [sps_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"
module sps_checker (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        irq,
    input wire logic        busy
);
    logic en_q;
    logic rb_q;
    // mirrors irq enable; rb_q marks a buffer read since the last frame
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            en_q <= 1'b0;
            rb_q <= 1'b0;
        end else begin
            if (wr && addr == `SPS_ADDR_IRQ_EN) en_q <= wdata[0];
            rb_q <= !busy && (rb_q || (rd && addr == `SPS_ADDR_BUF));
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_srd; $past(rd) && $past(addr) == `SPS_ADDR_STAT; endsequence
    sequence s_end;
        $fell(busy) ##[2:6] (rd && addr == `SPS_ADDR_STAT);
    endsequence
    property p_hi; s_srd |-> rdata[15:8] == 8'h00; endproperty
    property p_i2c; s_srd |-> rdata[5:1] == 5'h00; endproperty
    property p_bfs; s_end |=> rdata[`SPS_BIT_BF]; endproperty
    property p_bfc;
        $past(rd) && $past(addr) == `SPS_ADDR_STAT && $past(rb_q, 2)
            |-> !rdata[`SPS_BIT_BF];
    endproperty
    property p_irq; $fell(busy) && en_q |-> ##[1:4] irq; endproperty
    property p_nord; !$past(rd) |-> rdata == 16'h0000; endproperty
    a_hi: assert property (p_hi) else $error("high byte set");
    a_i2c: assert property (p_i2c) else $error("i2c bits set");
    a_bfs: assert property (p_bfs) else $error("full flag missing");
    a_bfc: assert property (p_bfc) else $error("full flag stuck");
    a_irq: assert property (p_irq) else $error("irq missing");
    a_nord: assert property (p_nord) else $error("rdata not idle");
endmodule : sps_checker
bind sps_port sps_checker chk_u (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .busy(busy));
`default_nettype wire

// [sps_defines.svh]
// Notes on behaviour
// R01: only low byte exists; high byte reads zero
// R02: master samples at end when phase select set
// R03: software keeps phase select clear as slave
// R04: edge select picks transmit clock transition
// R05: buffer full set when receive completes
// R06: i2c-only status bits read zero here
// R07: reading data buffer clears buffer full
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
`define SPS_ADDR_STAT     4'h0
`define SPS_ADDR_BUF      4'h1
`define SPS_ADDR_IRQ_STAT 4'h2
`define SPS_ADDR_IRQ_EN   4'h3
`define SPS_ADDR_IRQ_CLR  4'h4
`define SPS_ADDR_CTRL     4'h5
`define SPS_BIT_SMP       7
`define SPS_BIT_CKE       6
`define SPS_BIT_BF        0
`define SPS_BIT_CPOL      1
`define SPS_BIT_MASTER    0
`define SPS_BIT_ENABLE    2
`define SPS_RESET_STAT    8'h00
`define SPS_DIV_HALF      8'h04
`endif

// [sps_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module sps_peer (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       sck,
    input  wire logic       sel,
    input  wire logic       sdo,
    input  wire logic       cke,
    input  wire logic [7:0] tx,
    output logic            sdi,
    output logic      [7:0] rx
);
    logic       sck_q;
    logic       sel_q;
    logic [7:0] sh_q;
    // launches tx on the transmit edge, takes sdo on the other edge
    always_ff @(posedge mclk) begin
        sck_q <= sck;
        sel_q <= sel;
        if (rst) {sdi, sh_q, rx} <= '0;
        else if (!sel) sdi <= ~sdi; // released line keeps moving
        else if (!sel_q) {sdi, sh_q} <= cke ? {tx, 1'b0} : {sdi, tx};
        else if (sck != sck_q && sck != cke) {sdi, sh_q} <= {sh_q, 1'b0};
        if (sel_q && sck != sck_q && sck == cke) rx <= {rx[6:0], sdo};
    end
endmodule : sps_peer
`default_nettype wire

// [sps_pkg.sv]
package sps_pkg;
    typedef enum logic [1:0] {
        SPS_IDLE  = 2'b00,
        SPS_LEAD  = 2'b01,
        SPS_TRAIL = 2'b10
    } sps_state_e;
endpackage : sps_pkg

// [sps_port.sv]
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"
module sps_port (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    output logic             irq,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        sck_i,
    output logic             sdo,
    input  wire logic        sdi,
    output logic             busy
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [1:0] sck_s_q, sdi_s_q;
    logic       sck_prev_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sck_s_q    <= 2'h0;
            sdi_s_q    <= 2'h0;
            sck_prev_q <= 1'b0;
        end else if (ce) begin
            sck_s_q    <= {sck_s_q[0], sck_i};
            sdi_s_q    <= {sdi_s_q[0], sdi};
            sck_prev_q <= sck_s_q[1];
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic       smp_q, cke_q, bf_q, cpol_q, master_q, en_q;
    logic       irq_stat_q, irq_en_q;
    logic [7:0] buf_q, shift_q, div_q;
    logic [2:0] cnt_q;
    logic       done;
    sps_pkg::sps_state_e st_q;

    // software writable control; upper byte ignored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            smp_q    <= 1'b0;
            cke_q    <= 1'b0;
            cpol_q   <= 1'b0;
            master_q <= 1'b0;
            en_q     <= 1'b0;
            irq_en_q <= 1'b0;
        end else if (ce && wr) begin
            if (addr == `SPS_ADDR_STAT) begin
                smp_q <= wdata[`SPS_BIT_SMP]; // R01
                cke_q <= wdata[`SPS_BIT_CKE];
            end
            if (addr == `SPS_ADDR_CTRL) begin
                master_q <= wdata[`SPS_BIT_MASTER];
                cpol_q   <= wdata[`SPS_BIT_CPOL];
                en_q     <= wdata[`SPS_BIT_ENABLE];
            end
            if (addr == `SPS_ADDR_IRQ_EN)
                irq_en_q <= wdata[`SPS_BIT_BF];
        end
    end

    // buffer full: set wins over clear-by-read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bf_q <= 1'b0;
        end else if (ce) begin
            if (done)
                bf_q <= 1'b1; // R05
            else if (rd && addr == `SPS_ADDR_BUF)
                bf_q <= 1'b0; // R07
        end
    end

    // sticky receive-done event, write-one clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= 1'b0;
        end else if (ce) begin
            if (done)
                irq_stat_q <= 1'b1;
            else if (wr && addr == `SPS_ADDR_IRQ_CLR
                     && wdata[`SPS_BIT_BF])
                irq_stat_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // shifter
    // ------------------------------------------------------------
    // lead edge: idle->active; trail edge: active->idle.
    // transmit on trail when cke set, else on lead (sample other).
    logic sck_act, lead_e, trail_e, tx_e, rx_e, tx_on_trail;
    logic [7:0] nxt_shift;
    assign sck_act     = sck_s_q[1] ^ cpol_q;
    assign lead_e      = !master_q && sck_act && !(sck_prev_q ^ cpol_q);
    assign trail_e     = !master_q && !sck_act && (sck_prev_q ^ cpol_q);
    assign tx_on_trail = cke_q; // R04
    assign tx_e        = tx_on_trail ? trail_e : lead_e;
    assign rx_e        = tx_on_trail ? lead_e : trail_e;
    assign nxt_shift   = {shift_q[6:0], sdi_s_q[1]};

    // master: smp set samples at end of bit time, else middle.
    // a bit time runs from launch edge to launch edge, so its middle
    // and end move with cke; cke clear with end sampling needs one
    // extra idle half period after the last trail edge
    logic m_mid, m_end, m_samp, m_last, tail_q;
    assign m_mid  = (st_q == sps_pkg::SPS_LEAD) && div_q == 8'h00;
    assign m_end  = (st_q == sps_pkg::SPS_TRAIL) && div_q == 8'h00;
    assign m_samp = cke_q ? (smp_q ? m_end : m_mid)
                          : (smp_q ? m_mid && (cnt_q != 3'h0 || tail_q)
                                   : m_end); // R02
    assign m_last = (cke_q || !smp_q) ? (m_end && cnt_q == 3'h7)
                                      : (m_mid && tail_q);
    // R03: slave mode assumes smp_q is clear; it is not used there
    assign done   = master_q ? m_last
                             : (rx_e && cnt_q == 3'h7 && en_q);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q    <= sps_pkg::SPS_IDLE;
            div_q   <= 8'h00;
            cnt_q   <= 3'h0;
            shift_q <= 8'h00;
            buf_q   <= 8'h00;
            sck_o   <= 1'b0;
            sdo     <= 1'b0;
            tail_q  <= 1'b0;
        end else if (ce) begin
            if (done)
                buf_q <= (master_q && !m_samp) ? shift_q : nxt_shift;
            if (wr && addr == `SPS_ADDR_BUF && en_q) begin
                shift_q <= wdata[7:0];
                sdo     <= wdata[7];
                tail_q  <= 1'b0;
                cnt_q   <= 3'h0;
                if (master_q) begin
                    st_q  <= sps_pkg::SPS_LEAD;
                    div_q <= `SPS_DIV_HALF;
                    sck_o <= cpol_q;
                end
            end else if (master_q) begin
                case (st_q)
                    sps_pkg::SPS_IDLE: begin
                        sck_o <= cpol_q;
                    end
                    sps_pkg::SPS_LEAD: begin
                        if (m_samp)
                            shift_q <= nxt_shift;
                        if (div_q == 8'h00) begin
                            div_q <= `SPS_DIV_HALF;
                            if (tail_q) begin
                                st_q   <= sps_pkg::SPS_IDLE;
                                tail_q <= 1'b0;
                            end else begin
                                st_q  <= sps_pkg::SPS_TRAIL;
                                sck_o <= ~cpol_q;
                                if (!cke_q)
                                    sdo <= m_samp ? nxt_shift[7]
                                                  : shift_q[7]; // R04
                            end
                        end else
                            div_q <= div_q - 8'h01;
                    end
                    sps_pkg::SPS_TRAIL: begin
                        if (m_samp)
                            shift_q <= nxt_shift;
                        if (div_q == 8'h00) begin
                            sck_o <= cpol_q;
                            div_q <= `SPS_DIV_HALF;
                            cnt_q <= cnt_q + 3'h1;
                            if (cke_q)
                                sdo <= m_samp ? nxt_shift[7]
                                              : shift_q[7]; // R04
                            if (cnt_q == 3'h7) begin
                                // end sampling with cke clear needs a tail
                                tail_q <= !cke_q && smp_q;
                                st_q   <= (!cke_q && smp_q)
                                          ? sps_pkg::SPS_LEAD
                                          : sps_pkg::SPS_IDLE;
                            end else
                                st_q <= sps_pkg::SPS_LEAD;
                        end else
                            div_q <= div_q - 8'h01;
                    end
                    default: st_q <= sps_pkg::SPS_IDLE;
                endcase
            end else begin
                if (rx_e && en_q) begin
                    shift_q <= nxt_shift;
                    cnt_q   <= cnt_q + 3'h1;
                end
                if (tx_e && en_q)
                    sdo <= shift_q[7];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs and read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata  <= 16'h0000;
            irq    <= 1'b0;
            sck_oe <= 1'b0;
            busy   <= 1'b0;
        end else if (ce) begin
            irq    <= irq_stat_q & irq_en_q;
            sck_oe <= master_q & en_q;
            busy   <= st_q != sps_pkg::SPS_IDLE;
            rdata  <= 16'h0000;
            if (rd) begin
                case (addr)
                    // R06: i2c-only bits 5..1 read as zero
                    `SPS_ADDR_STAT:     rdata <= {8'h00, smp_q, cke_q,
                                                  5'h00, bf_q}; // R01
                    `SPS_ADDR_BUF:      rdata <= {8'h00, buf_q};
                    `SPS_ADDR_IRQ_STAT: rdata <= {15'h0000, irq_stat_q};
                    `SPS_ADDR_IRQ_EN:   rdata <= {15'h0000, irq_en_q};
                    `SPS_ADDR_CTRL:     rdata <= {13'h0000, en_q, cpol_q,
                                                  master_q};
                    default:            rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule : sps_port
`default_nettype wire
